// ---- test/host_bus_slave_port_props.sv ----
// assertions on the host bus between the host end and the device end
`timescale 1ns/1ps
module host_bus_slave_port_props
   import host_port_pkg::*;
#(
   parameter int READ_LAT = 2
)
(
   // bus signals
   input wire logic              clk_sys_i,
   input wire logic              rst_n_i,
   input wire logic [ADDR_W:1]   addr,
   input wire logic              upper_byte_strobe_n,
   input wire logic              lower_byte_strobe_n,
   input wire logic              device_select_strobe_n,
   input wire logic              read_not_write,
   input wire logic              host_data_oe,
   input wire logic [DATA_W-1:0] dev_data,
   input wire logic              dev_data_oe,
   input wire logic              transfer_ack_pull,
   input wire logic              transfer_ack_n
);
   localparam int RD_MIN = READ_LAT + 1;
   localparam int RD_MAX = READ_LAT + 2;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence take_wr;
      $fell(device_select_strobe_n) && !read_not_write;
   endsequence
   sequence take_rd;
      $fell(device_select_strobe_n) && read_not_write;
   endsequence
   a_write_ack_late: assert property (take_wr |-> (!transfer_ack_pull)[*2]
      ##[1:2] transfer_ack_pull) else $error("write ack timing");
   a_read_ack_late: assert property (take_rd |-> (!transfer_ack_pull)[*3]
      ##[RD_MIN:RD_MAX] transfer_ack_pull) else $error("read ack timing");
   a_read_data_ready: assert property ($rose(transfer_ack_pull) && read_not_write
      |-> dev_data_oe && $stable(dev_data)) else $error("read data not ready at ack");
   a_release_end: assert property ($rose(device_select_strobe_n)
      |-> ##[1:3] !transfer_ack_pull && !dev_data_oe) else $error("outputs not released");
   a_idle_quiet: assert property (device_select_strobe_n[*4]
      |-> !transfer_ack_pull && !dev_data_oe) else $error("drive while unselected");
   a_word_above_dram: assert property (!device_select_strobe_n && addr[ADDR_W]
      |-> upper_byte_strobe_n == lower_byte_strobe_n) else $error("byte access above dram");
   a_strobe_some: assert property (!device_select_strobe_n
      |-> !(upper_byte_strobe_n && lower_byte_strobe_n)) else $error("no lane strobed");
   a_cycle_held: assert property (!device_select_strobe_n && !$past(device_select_strobe_n)
      |-> $stable(addr) && $stable(read_not_write)) else $error("cycle changed while selected");
   a_no_fight: assert property (!(host_data_oe && dev_data_oe))
      else $error("both ends drive data");
   a_ack_wired: assert property (!transfer_ack_n |-> transfer_ack_pull
      && !$past(device_select_strobe_n)) else $error("ack low without a selected cycle");
endmodule

// ---- test/test_host_bus_slave_port.sv ----
// self-checking bench joining the host end and the device end
`timescale 1ns/1ps
module test_host_bus_slave_port;
   import host_port_pkg::*;
   localparam int RL = 1;
   logic              clk_sys_i = 1'b0;
   logic              rst_n_i = 1'b0;
   logic              cmd_valid_i = 1'b0;
   logic              cmd_read_i = 1'b0;
   logic [ADDR_W:1]   cmd_addr_i = '0;
   logic [1:0]        cmd_bytes_i = 2'h3;
   logic [DATA_W-1:0] cmd_wdata_i = '0;
   logic [DATA_W-1:0] rdata_i = '0;
   logic              cmd_ready_o;
   logic              done_o;
   logic [DATA_W-1:0] rdata_o;
   logic              req_o;
   logic              req_write_o;
   logic [1:0]        req_target_o;
   logic [ADDR_W-1:0] req_addr_o;
   logic [DATA_W-1:0] req_wdata_o;
   logic [1:0]        req_bytes_o;
   logic              req_error_o;
   logic              seen = 1'b0;
   int                err_count = 0;
   int                total_checks = 0;

   host_bus_if bus ();
   host_bus_host i_host_bus_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .cmd_valid_i(cmd_valid_i), .cmd_read_i(cmd_read_i), .cmd_addr_i(cmd_addr_i),
      .cmd_bytes_i(cmd_bytes_i), .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o),
      .done_o(done_o), .rdata_o(rdata_o), .bus(bus.host));
   host_bus_device #(.READ_LAT(RL)) i_host_bus_device (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .bus(bus.device), .req_o(req_o), .req_write_o(req_write_o),
      .req_target_o(req_target_o), .req_addr_o(req_addr_o), .req_wdata_o(req_wdata_o),
      .req_bytes_o(req_bytes_o), .req_error_o(req_error_o), .rdata_i(rdata_i));
   host_bus_slave_port_props #(.READ_LAT(RL)) i_props (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .addr(bus.addr), .upper_byte_strobe_n(bus.upper_byte_strobe_n),
      .lower_byte_strobe_n(bus.lower_byte_strobe_n), .read_not_write(bus.read_not_write),
      .device_select_strobe_n(bus.device_select_strobe_n), .host_data_oe(bus.host_data_oe),
      .dev_data(bus.dev_data), .dev_data_oe(bus.dev_data_oe),
      .transfer_ack_pull(bus.transfer_ack_pull), .transfer_ack_n(bus.transfer_ack_n));

   always #20 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (req_o === 1'b1) seen <= 1'b1;

   // one whole host command, waits for done under a bound
   task automatic xfer(input logic rd, input logic [ADDR_W:1] a, input logic [1:0] b,
                       input logic [DATA_W-1:0] wd);
      int n;
      n = 0;
      @(negedge clk_sys_i);
      seen = 1'b0;
      cmd_read_i = rd;
      cmd_addr_i = a;
      cmd_bytes_i = b;
      cmd_wdata_i = wd;
      cmd_valid_i = 1'b1;
      @(negedge clk_sys_i);
      cmd_valid_i = 1'b0;
      total_checks++;
      if (cmd_ready_o !== 1'b0) begin
         err_count++;
         $display("wrong value at %0t: command not taken", $time);
      end
      while (done_o !== 1'b1 && n < 200) begin
         @(negedge clk_sys_i);
         n++;
      end
      total_checks++;
      if (n >= 200 || cmd_ready_o !== 1'b1) begin
         err_count++;
         $display("wrong value at %0t: no done", $time);
      end
   endtask

   task automatic t_targets();
      logic [ADDR_W:1] a;
      for (int t = 0; t < 4; t++) begin
         a = {t[1:0], 18'h0_1234};
         xfer(1'b0, a, 2'h3, 16'ha500 + 16'(t));
         total_checks++;
         if (!(seen && req_write_o === 1'b1 && req_target_o === t[1:0])) begin
            err_count++;
            $display("wrong value at %0t: target", $time);
         end
         total_checks++;
         if (req_addr_o !== a || req_wdata_o !== 16'ha500 + 16'(t)) begin
            err_count++;
            $display("wrong value at %0t: wdata", $time);
         end
      end
   endtask

   task automatic t_lanes();
      xfer(1'b0, 20'h0_0010, 2'h2, 16'h1234);
      total_checks++;
      if (!(seen && req_bytes_o === 2'h2 && req_error_o === 1'b0)) begin
         err_count++;
         $display("wrong value at %0t: upper lane", $time);
      end
      xfer(1'b0, 20'h4_0010, 2'h1, 16'h1234);
      total_checks++;
      if (!(seen && req_bytes_o === 2'h1 && req_error_o === 1'b0)) begin
         err_count++;
         $display("wrong value at %0t: lower lane", $time);
      end
      xfer(1'b0, 20'h8_0004, 2'h2, 16'hbeef);
      total_checks++;
      if (!(seen && req_bytes_o === 2'h3 && req_error_o === 1'b0)) begin
         err_count++;
         $display("wrong value at %0t: forced word", $time);
      end
   endtask

   task automatic t_reads();
      rdata_i = 16'hc3a5;
      xfer(1'b1, 20'h8_0002, 2'h3, 16'h0000);
      total_checks++;
      if (rdata_o !== 16'hc3a5 || req_target_o !== TGT_REGS) begin
         err_count++;
         $display("wrong value at %0t: reg read", $time);
      end
      rdata_i = 16'h5aa5;
      xfer(1'b1, 20'hc_0000, 2'h3, 16'h0000);
      total_checks++;
      if (!(rdata_o === 16'h0000 && req_error_o === 1'b1 && !seen)) begin
         err_count++;
         $display("wrong value at %0t: buffer read", $time);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (20) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      t_lanes();
      t_reads();
      t_targets();
      final_report();
   end

   // hang guard, far beyond the nine short commands above
   initial begin
      #(40 * 20000);
      err_count++;
      final_report();
   end
endmodule

// ---- verilog/access_decoder.sv ----
// target and size decoder for one host access
`timescale 1ns/1ps
module access_decoder
   import host_port_pkg::*;
(
   // access
   input  wire logic [ADDR_W:1] addr_i,
   input  wire logic [1:0]      stb_n_i,
   input  wire logic            read_i,
   // decode
   output logic [1:0]           target_o,
   output xfer_size_t           size_o,
   output logic                 legal_o
);
   always_comb begin
      target_o = addr_i[ADDR_W:ADDR_W-1];
      size_o   = decode_strobes(stb_n_i);
      legal_o  = 1'b1;
      if (target_o[1] && (stb_n_i[1] != stb_n_i[0])) begin
         legal_o = 1'b0;
      end
      if (size_o == SIZE_NONE) begin
         legal_o = 1'b0;
      end
      // input buffer takes writes only
      if (target_o == TGT_CIB && read_i) begin
         legal_o = 1'b0;
      end
   end
endmodule

// ---- verilog/host_bus_device.sv ----
// device end of the host bus slave port
`timescale 1ns/1ps
// How it works
// - strobe pair encodes word, byte, or none
// - byte transfers only for dram targets
// - host asserts both strobes above dram
// - top two address bits pick target
// - host asserts select for every cycle
// - twenty bit word address, no bit0
// - device drives data only for reads
// - read line high reads, low writes
// - read ack only after data ready
// - write ack only after data latched
// - ack is open drain pull low
module host_bus_device
   import host_port_pkg::*;
#(
   parameter int READ_LAT = 2
)
(
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   // host bus
   host_bus_if.device             bus,
   // internal side
   output logic                   req_o,
   output logic                   req_write_o,
   output logic [1:0]             req_target_o,
   output logic [ADDR_W-1:0]      req_addr_o,
   output logic [DATA_W-1:0]      req_wdata_o,
   output logic [1:0]             req_bytes_o,
   output logic                   req_error_o,
   input  wire logic [DATA_W-1:0] rdata_i
);
   typedef enum logic [1:0] {IDLE, WAIT_DATA, ACKED} state_t;

   //----------------------------------------
   // decode
   //----------------------------------------
   logic [1:0]  target;
   xfer_size_t  size;
   logic        legal;
   state_t      state_reg;
   logic [7:0]  wait_reg;
   logic        sel;
   logic        take;
   logic        data_ready;
   logic        read_phase;

   // select is a level; the rest of the bus means nothing while it is high
   assign sel = ~bus.device_select_strobe_n;

   access_decoder i_access_decoder (
      .addr_i   (bus.addr),
      .stb_n_i  ({bus.upper_byte_strobe_n, bus.lower_byte_strobe_n}),
      .read_i   (bus.read_not_write),
      .target_o (target),
      .size_o   (size),
      .legal_o  (legal)
   );

   //----------------------------------------
   // cycle conditions
   //----------------------------------------
   // ignore unselected bus
   // strobe-none cycles are never taken, so the host sees no ack for them
   assign take = (state_reg == IDLE) && sel && (size != SIZE_NONE);

   assign data_ready = (state_reg == WAIT_DATA) && sel && (wait_reg == 8'(READ_LAT));

   assign read_phase = sel && !req_write_o && (state_reg == WAIT_DATA || state_reg == ACKED);

   //----------------------------------------
   // cycle sequencer
   //----------------------------------------
   // a write is acked as soon as its data is latched; a read first waits READ_LAT + 1 cycles in WAIT_DATA
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= IDLE;
      end else begin
         unique case (state_reg)
            IDLE: begin
               if (take) begin
                  state_reg <= bus.read_not_write ? WAIT_DATA : ACKED;
               end
            end
            WAIT_DATA: begin
               // a host that drops select mid-read simply abandons the cycle
               if (!sel) begin
                  state_reg <= IDLE;
               end else if (data_ready) begin
                  state_reg <= ACKED;
               end
            end
            ACKED: begin
               if (!sel) begin
                  state_reg <= IDLE;
               end
            end
            default: begin
               state_reg <= IDLE;
            end
         endcase
      end
   end

   //----------------------------------------
   // read wait counter
   //----------------------------------------
   // eight bits only: a READ_LAT above 255 is compared by its low eight bits
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_reg <= 8'h00;
      end else if (take) begin
         wait_reg <= 8'h00;
      end else if (state_reg == WAIT_DATA && sel && !data_ready) begin
         wait_reg <= wait_reg + 8'h01;
      end
   end

   //----------------------------------------
   // request pulse and error flag
   //----------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_o       <= 1'b0;
         req_error_o <= 1'b0;
      end else begin
         req_o <= 1'b0;
         if (take) begin
            // illegal access flagged, not issued
            // illegal cycles with a strobe set are still acked so a careless host does not hang on them
            req_o       <= legal;
            req_error_o <= ~legal;
         end
      end
   end

   //----------------------------------------
   // request capture
   //----------------------------------------
   // captured only at the take, so these hold until the next cycle
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_write_o  <= 1'b0;
         req_target_o <= TGT_DRAM0;
         req_addr_o   <= ADDR_RST;
         req_wdata_o  <= DATA_RST;
         req_bytes_o  <= 2'h0;
      end else if (take) begin
         req_addr_o   <= bus.addr;
         req_write_o  <= ~bus.read_not_write;
         req_target_o <= target;
         req_wdata_o  <= bus.data_bus;
         req_bytes_o  <= ~{bus.upper_byte_strobe_n, bus.lower_byte_strobe_n};
      end
   end

   //----------------------------------------
   // read data
   //----------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus.dev_data <= DATA_RST;
      end else if (data_ready) begin
         // data before ack on reads
         // an illegal read returns zero, never stale core data
         bus.dev_data <= req_error_o ? DATA_RST : rdata_i;
      end
   end

   //----------------------------------------
   // data bus drive
   //----------------------------------------
   // oe rises one cycle after the take, never later than the read data
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus.dev_data_oe <= 1'b0;
      end else begin
         bus.dev_data_oe <= read_phase;
      end
   end

   //----------------------------------------
   // acknowledge pin
   //----------------------------------------
   // the pull follows select through one flop, so it lets go a cycle after the host
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus.transfer_ack_pull <= 1'b0;
      end else begin
         bus.transfer_ack_pull <= sel && (state_reg == ACKED);
      end
   end
endmodule

// ---- verilog/host_bus_host.sv ----
// host end of the host bus slave port
`timescale 1ns/1ps
module host_bus_host
   import host_port_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   // user command
   input  wire logic              cmd_valid_i,
   input  wire logic              cmd_read_i,
   input  wire logic [ADDR_W:1]   cmd_addr_i,
   input  wire logic [1:0]        cmd_bytes_i,
   input  wire logic [DATA_W-1:0] cmd_wdata_i,
   output logic                   cmd_ready_o,
   output logic                   done_o,
   output logic [DATA_W-1:0]      rdata_o,
   // host bus
   host_bus_if.host               bus
);
   typedef enum logic [1:0] {IDLE, ACTIVE, FINISH} state_t;
   state_t state_reg;
   logic   need_word;

   assign need_word = cmd_addr_i[ADDR_W];

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg                  <= IDLE;
         cmd_ready_o                <= 1'b1;
         done_o                     <= 1'b0;
         rdata_o                    <= DATA_RST;
         bus.addr                   <= ADDR_RST;
         bus.upper_byte_strobe_n    <= 1'b1;
         bus.lower_byte_strobe_n    <= 1'b1;
         bus.device_select_strobe_n <= 1'b1;
         bus.read_not_write         <= 1'b1;
         bus.host_data              <= DATA_RST;
         bus.host_data_oe           <= 1'b0;
      end else begin
         done_o <= 1'b0;
         unique case (state_reg)
            IDLE: begin
               if (cmd_valid_i) begin
                  cmd_ready_o <= 1'b0;
                  bus.addr    <= cmd_addr_i;
                  bus.upper_byte_strobe_n <= need_word ? 1'b0 : ~cmd_bytes_i[1];
                  bus.lower_byte_strobe_n <= need_word ? 1'b0 : ~cmd_bytes_i[0];
                  bus.device_select_strobe_n <= 1'b0;
                  bus.read_not_write <= cmd_read_i;
                  bus.host_data      <= cmd_wdata_i;
                  bus.host_data_oe   <= ~cmd_read_i;
                  state_reg          <= ACTIVE;
               end
            end
            ACTIVE: begin
               if (!bus.transfer_ack_n) begin
                  rdata_o                    <= bus.data_bus;
                  bus.device_select_strobe_n <= 1'b1;
                  bus.upper_byte_strobe_n    <= 1'b1;
                  bus.lower_byte_strobe_n    <= 1'b1;
                  bus.host_data_oe           <= 1'b0;
                  state_reg                  <= FINISH;
               end
            end
            FINISH: begin
               // wait for ack release so cycles never overlap
               if (bus.transfer_ack_n) begin
                  done_o      <= 1'b1;
                  cmd_ready_o <= 1'b1;
                  state_reg   <= IDLE;
               end
            end
            default: state_reg <= IDLE;
         endcase
      end
   end
endmodule

// ---- verilog/host_bus_if.sv ----
// interface joining the host and the device port
`timescale 1ns/1ps
interface host_bus_if;
   import host_port_pkg::*;
   logic [ADDR_W:1]   addr;
   logic              upper_byte_strobe_n;
   logic              lower_byte_strobe_n;
   logic              device_select_strobe_n;
   logic              read_not_write;
   logic [DATA_W-1:0] host_data;
   logic              host_data_oe;
   logic [DATA_W-1:0] dev_data;
   logic              dev_data_oe;
   logic              transfer_ack_pull;
   logic [DATA_W-1:0] data_bus;
   logic              transfer_ack_n;

   // wire resolution: pull-up on the ack, device wins on contention
   assign data_bus       = dev_data_oe ? dev_data : (host_data_oe ? host_data : DATA_RST);
   assign transfer_ack_n = ~transfer_ack_pull;

   modport host (
      output addr, upper_byte_strobe_n, lower_byte_strobe_n, device_select_strobe_n,
      output read_not_write, host_data, host_data_oe,
      input  data_bus, transfer_ack_n
   );
   modport device (
      input  addr, upper_byte_strobe_n, lower_byte_strobe_n, device_select_strobe_n,
      input  read_not_write, data_bus,
      output dev_data, dev_data_oe, transfer_ack_pull
   );
endinterface

// ---- verilog/host_port_pkg.sv ----
// shared constants and types for the host bus slave port
package host_port_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int TGT_HI = 19;
   localparam int TGT_LO = 18;
   localparam logic [1:0] TGT_DRAM0 = 2'h0;
   localparam logic [1:0] TGT_DRAM1 = 2'h1;
   localparam logic [1:0] TGT_REGS  = 2'h2;
   localparam logic [1:0] TGT_CIB   = 2'h3;
   localparam logic [1:0] STB_WORD  = 2'h0;
   localparam logic [1:0] STB_UPPER = 2'h1;
   localparam logic [1:0] STB_LOWER = 2'h2;
   localparam logic [1:0] STB_NONE  = 2'h3;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 20'h0_0000;

   typedef enum logic [1:0] {
      SIZE_NONE,
      SIZE_UPPER,
      SIZE_LOWER,
      SIZE_WORD
   } xfer_size_t;

   // decode byte strobes {upper_n, lower_n}
   function automatic xfer_size_t decode_strobes(input logic [1:0] stb_n);
      xfer_size_t s;
      s = SIZE_NONE;
      unique case (stb_n)
         STB_WORD:  s = SIZE_WORD;
         STB_UPPER: s = SIZE_UPPER;
         STB_LOWER: s = SIZE_LOWER;
         STB_NONE:  s = SIZE_NONE;
      endcase
      return s;
   endfunction
endpackage
